// *** hw/fpcr_top.sv ***
// Command interpreter of the flash programming executive
`timescale 1ns/100ps
`default_nettype none
module fpcr_top
	import fpcr_pkg::*;
(
	input  wire logic        clk,           // 20 MHz clock
	input  wire logic        reset_n,       // Async reset, active low
	input  wire logic        cmd_valid,     // Command word offered
	input  wire logic [31:0] cmd_word,      // Command word
	output logic             cmd_ready,     // Command word taken
	output logic             rsp_valid,     // Response word offered
	output logic [31:0]      rsp_word,      // Response word
	input  wire logic        rsp_ready,     // Response word taken
	output logic             mem_req,       // Memory access request
	output logic             mem_write,     // 1 program, 0 read
	output logic [31:0]      mem_addr,      // Memory byte address
	output logic [31:0]      mem_wdata,     // Word to program
	input  wire logic        mem_done,      // Access finished, pulse
	input  wire logic        mem_error,     // Program failed, with done
	input  wire logic [31:0] mem_rdata      // Read word, with done
);
	import fpcr_pkg::*;

	typedef struct packed {
		fpcr_state_t st;
		logic [15:0] op;
		logic [15:0] count;
		logic [31:0] addr;
		logic [31:0] row_addr;
		logic [31:0] rows_left;
		logic [7:0]  widx;
		logic        row_err;
		logic        failed;
		logic        cmd_ready;
		logic        rsp_valid;
		logic [31:0] rsp_word;
		logic        mem_req;
		logic        mem_write;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
	} fpcr_top_t;

	fpcr_top_t s_q, s_d;
	logic        rst_n;
	logic        pipe_load;
	logic [31:0] pipe_word;
	logic        pipe_take;
	logic        pipe_held;
	logic [31:0] pipe_held_word;
	logic        cmd_fire;
	logic        rsp_free;
	logic        last_word;
	logic        err;

	fpcr_reset_sync u_rst (
		.clk        (clk),
		.reset_n    (reset_n),
		.rst_n_sync (rst_n)
	);

	fpcr_resp_pipe u_pipe (
		.clk       (clk),
		.rst_n     (rst_n),
		.load      (pipe_load),
		.load_word (pipe_word),
		.take      (pipe_take),
		.held      (pipe_held),
		.held_word (pipe_held_word)
	);

	assign cmd_fire = s_q.cmd_ready && cmd_valid;
	assign rsp_free = !s_q.rsp_valid || rsp_ready;

	// ============================================================
	// Sequencer
	always_comb begin
		s_d       = s_q;
		pipe_load = 1'b0;
		pipe_word = 32'h0000_0000;
		pipe_take = 1'b0;
		last_word = (s_q.op == FPCR_OP_WORD_WRITE) || (s_q.widx == FPCR_ROW_LAST);
		err       = s_q.row_err || (s_q.mem_req && mem_error);
		if (s_q.rsp_valid && rsp_ready) begin
			s_d.rsp_valid = 1'b0;
		end
		if (s_q.mem_req && mem_done) begin
			s_d.mem_req = 1'b0;
		end
		case (s_q.st)
		FPCR_IDLE: begin
			s_d.cmd_ready = rsp_free;
			if (cmd_fire) begin
				s_d.op    = cmd_word[FPCR_HI:FPCR_MID];
				s_d.count = cmd_word[FPCR_MID-1:0];
				s_d.failed = 1'b0;
				s_d.row_err = 1'b0;
				if (cmd_word[FPCR_HI:FPCR_MID] > FPCR_OP_WORD_WRITE) begin
					s_d.cmd_ready = 1'b0;
					s_d.rsp_valid = 1'b1;
					s_d.rsp_word  = {cmd_word[FPCR_HI:FPCR_MID],
						unknown_command_code};
				end else begin
					s_d.st = FPCR_ADDR_HI;
				end
			end
		end
		FPCR_ADDR_HI: begin
			s_d.cmd_ready = 1'b1;
			if (cmd_fire) begin
				s_d.addr[31:16] = cmd_word[15:0];
				s_d.st          = FPCR_ADDR_LO;
			end
		end
		FPCR_ADDR_LO: begin
			if (cmd_fire) begin
				s_d.addr[15:0] = cmd_word[15:0];
				s_d.row_addr   = {s_q.addr[31:16], cmd_word[15:0]};
				s_d.widx       = 8'h00;
				s_d.rows_left  = 32'h0000_0001;
				if (s_q.op == FPCR_OP_PROGRAM) begin
					s_d.st = FPCR_LEN_HI;
				end else if (s_q.op == FPCR_OP_READ) begin
					s_d.cmd_ready = 1'b0;
					s_d.st        = FPCR_READ_REQ;
				end else begin
					s_d.st = FPCR_DATA;
				end
			end
		end
		FPCR_LEN_HI: begin
			if (cmd_fire) begin
				s_d.rows_left[31:16] = cmd_word[15:0];
				s_d.st               = FPCR_LEN_LO;
			end
		end
		FPCR_LEN_LO: begin
			if (cmd_fire) begin
				s_d.rows_left = {s_q.rows_left[31:16], cmd_word[15:0]}
					>> FPCR_ROW_SHIFT;
				s_d.st = FPCR_DATA;
			end
		end
		FPCR_DATA: begin
			if (cmd_fire) begin
				// One word per flash access; fail is sticky for the command
				s_d.cmd_ready = 1'b0;
				s_d.mem_req   = !s_q.failed;
				s_d.mem_write = 1'b1;
				s_d.mem_addr  = s_q.addr;
				s_d.mem_wdata = cmd_word;
				s_d.addr      = s_q.addr + 32'h0000_0004;
				s_d.st        = FPCR_MEM_WAIT;
			end
		end
		FPCR_MEM_WAIT: begin
			// Error kept here, so a row end stalled on a busy answer slot still reports it
			s_d.row_err = err;
			if (!s_q.mem_req || mem_done) begin
				if (!last_word) begin
					s_d.widx      = s_q.widx + 8'h01;
					s_d.cmd_ready = 1'b1;
					s_d.st        = FPCR_DATA;
				end else if (s_q.op != FPCR_OP_PROGRAM) begin
					s_d.rsp_valid = 1'b1;
					s_d.rsp_word  = {s_q.op, err ? FPCR_RES_FAIL : FPCR_RES_PASS};
					s_d.st        = FPCR_IDLE;
				end else if (rsp_free) begin
					// Row done: answer one row behind, held answer first
					s_d.widx      = 8'h00;
					s_d.row_err   = 1'b0;
					s_d.rows_left = s_q.rows_left - 32'h0000_0001;
					s_d.row_addr  = s_q.row_addr + FPCR_ROW_BYTES;
					pipe_load     = 1'b1;
					pipe_word     = {s_q.row_addr[15:0], err ? FPCR_RES_FAIL : FPCR_RES_PASS};
					if (pipe_held) begin
						pipe_take     = 1'b1;
						s_d.rsp_valid = 1'b1;
						s_d.rsp_word  = pipe_held_word;
					end
					if (err) begin
						s_d.failed = 1'b1;
					end
					if (s_q.rows_left <= 32'h0000_0001 || err) begin
						s_d.st = FPCR_FLUSH;
					end else begin
						s_d.cmd_ready = 1'b1;
						s_d.st        = FPCR_DATA;
					end
				end
			end
		end
		FPCR_FLUSH: begin
			if (rsp_free && pipe_held) begin
				pipe_take     = 1'b1;
				s_d.rsp_valid = 1'b1;
				s_d.rsp_word  = pipe_held_word;
				s_d.widx      = 8'h00;
				if (s_q.failed && s_q.rows_left != 32'h0000_0000) begin
					s_d.cmd_ready = 1'b1;
					s_d.st        = FPCR_DRAIN;
				end else begin
					s_d.st = FPCR_IDLE;
				end
			end
		end
		FPCR_DRAIN: begin
			// Words of the aborted command still in flight are dropped
			if (cmd_fire) begin
				s_d.widx = s_q.widx + 8'h01;
				if (s_q.widx == FPCR_ROW_LAST) begin
					s_d.widx      = 8'h00;
					s_d.rows_left = s_q.rows_left - 32'h0000_0001;
					if (s_q.rows_left <= 32'h0000_0001) begin
						s_d.cmd_ready = 1'b0;
						s_d.st        = FPCR_IDLE;
					end
				end
			end
		end
		FPCR_READ_REQ: begin
			if (rsp_free) begin
				s_d.rsp_valid = 1'b1;
				s_d.rsp_word  = {s_q.op, FPCR_RES_PASS};
				s_d.mem_write = 1'b0;
				s_d.st        = (s_q.count == 16'h0000) ? FPCR_IDLE : FPCR_READ_WAIT;
			end
		end
		FPCR_READ_WAIT: begin
			// Fetch only once the last answer is taken: read data has nowhere else to wait
			if (s_q.mem_req && mem_done) begin
				s_d.rsp_valid = 1'b1;
				s_d.rsp_word  = mem_rdata;
				s_d.count     = s_q.count - 16'h0001;
				s_d.addr      = s_q.addr + 32'h0000_0004;
				if (s_q.count == 16'h0001) begin
					s_d.st = FPCR_IDLE;
				end
			end else if (!s_q.mem_req && !s_q.rsp_valid) begin
				s_d.mem_req  = 1'b1;
				s_d.mem_addr = s_q.addr;
			end
		end
		default: begin
			s_d.st = FPCR_IDLE;
		end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q    <= '0;
			s_q.st <= FPCR_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_ready = s_q.cmd_ready;
	assign rsp_valid = s_q.rsp_valid;
	assign rsp_word  = s_q.rsp_word;
	assign mem_req   = s_q.mem_req;
	assign mem_write = s_q.mem_write;
	assign mem_addr  = s_q.mem_addr;
	assign mem_wdata = s_q.mem_wdata;
endmodule
`default_nettype wire

// *** hw/fpcr_pkg.sv ***
// Package of constants and types for the flash program command responder
// ============================================================
// Overview of operation
// - Response upper half echoes processed command code, except program answers (row address)
// - Result code: 0 pass, 2 fail, 3 unknown
// - Optional data words follow response header
// - Row write: address halves, one row, one header
// - Read: operand word count, 32-bit source address
// - Read returns header then packed data words
// - Program: address, byte length, then data words
// - One-row program answers when row arrives
// - Two-row program answers twice after both rows
// - Longer programs answer one row behind
// - Program error reports fail at row end, drops later rows
// - Program answer: address low bits, result code
// - Word write programs exactly one data word
// - Header: code high half, operand low half
// - Unknown code answers with unknown result
// - One command at a time, answer first
package fpcr_pkg;
	localparam logic [15:0] FPCR_OP_ROW_WRITE  = 16'h0000;
	localparam logic [15:0] FPCR_OP_READ       = 16'h0001;
	localparam logic [15:0] FPCR_OP_PROGRAM    = 16'h0002;
	localparam logic [15:0] FPCR_OP_WORD_WRITE = 16'h0003;
	localparam logic [15:0] FPCR_RES_PASS      = 16'h0000;
	localparam logic [15:0] FPCR_RES_FAIL      = 16'h0002;
	localparam logic [15:0] unknown_command_code = 16'h0003;
	// Row of 32 words (128 bytes); devices with 512-byte rows change this
	localparam int          FPCR_ROW_WORDS     = 32;
	localparam logic [7:0]  FPCR_ROW_LAST      = 8'h1F;
	localparam logic [31:0] FPCR_ROW_BYTES     = 32'h0000_0080;
	localparam int          FPCR_ROW_SHIFT     = 7;
	localparam int          FPCR_HI            = 31;
	localparam int          FPCR_MID           = 16;

	typedef enum logic [3:0] {
		FPCR_IDLE, FPCR_ADDR_HI, FPCR_ADDR_LO, FPCR_LEN_HI, FPCR_LEN_LO,
		FPCR_DATA, FPCR_MEM_WAIT, FPCR_READ_REQ, FPCR_READ_WAIT,
		FPCR_FLUSH, FPCR_DRAIN
	} fpcr_state_t;
endpackage

// *** hw/fpcr_reset_sync.sv ***
// Two-stage reset release synchroniser
`timescale 1ns/100ps
`default_nettype none
module fpcr_reset_sync (
	input  wire logic clk,        // System clock
	input  wire logic reset_n,    // Asynchronous reset in
	output var  logic rst_n_sync  // Synchronised release
);
	logic [1:0] sync_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_q <= 2'h0;
		end else begin
			sync_q <= {sync_q[0], 1'b1};
		end
	end
	assign rst_n_sync = sync_q[1];
endmodule
`default_nettype wire

// *** hw/fpcr_resp_pipe.sv ***
// Holds a pending program answer so answers lag data by one row
`timescale 1ns/100ps
`default_nettype none
module fpcr_resp_pipe
	import fpcr_pkg::*;
(
	input  wire logic        clk,        // System clock
	input  wire logic        rst_n,      // Synchronised reset
	input  wire logic        load,       // Capture an answer
	input  wire logic [31:0] load_word,  // Answer captured
	input  wire logic        take,       // Consume held answer
	output var  logic        held,       // An answer is held
	output var  logic [31:0] held_word   // Held answer
);
	typedef struct packed {
		logic        v;
		logic [31:0] w;
	} fpcr_pipe_t;
	fpcr_pipe_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (take) begin
			s_d.v = 1'b0;
		end
		if (load) begin
			s_d.v = 1'b1;
			s_d.w = load_word;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign held      = s_q.v;
	assign held_word = s_q.w;
endmodule
`default_nettype wire

// *** tb/fpcr_props.sv ***
// Port timing checker of the command responder
`timescale 1ns/100ps
`default_nettype none
module fpcr_props (
	input wire logic        clk,       // Clock
	input wire logic        reset_n,   // Reset, active low
	input wire logic        cmd_valid, // Word offered
	input wire logic        cmd_ready, // Word taken
	input wire logic        rsp_valid, // Answer offered
	input wire logic [31:0] rsp_word,  // Answer
	input wire logic        rsp_ready, // Answer taken
	input wire logic        mem_req,   // Access request
	input wire logic        mem_write, // Program access
	input wire logic [31:0] mem_addr,  // Access address
	input wire logic [31:0] mem_wdata, // Program word
	input wire logic        mem_done   // Access end
);
	// ========================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_rsp_valid_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid)
		else $error("answer withdrawn before taken");
	a_rsp_word_hold: assert property (rsp_valid && !rsp_ready |=> $stable(rsp_word))
		else $error("answer word changed while offered");
	a_req_hold: assert property (mem_req && !mem_done |=> mem_req)
		else $error("access request dropped early");
	a_req_fields_hold: assert property (mem_req && !mem_done |=>
		$stable(mem_addr) && $stable(mem_wdata) && $stable(mem_write))
		else $error("access fields moved during request");
	a_done_ends_req: assert property (mem_done |=> !mem_req)
		else $error("request kept after done");
	a_busy_refuses: assert property (mem_req |-> !cmd_ready)
		else $error("word taken while busy");
	a_reset_quiet: assert property ($rose(reset_n) |->
		(!cmd_ready && !rsp_valid && !mem_req)[*2] ##[1:2] cmd_ready)
		else $error("wrong start after reset");
	a_write_after_take: assert property ($rose(mem_req) && mem_write |->
		$past(cmd_valid && cmd_ready))
		else $error("program started without a word");
endmodule
bind fpcr_top fpcr_props u_props (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_ready(rsp_ready),
	.mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_done(mem_done));
`default_nettype wire

// *** tb/fpcr_mem_model.sv ***
// Flash memory behind the responder, answering after a set delay
`timescale 1ns/100ps
`default_nettype none
module fpcr_mem_model (
	input  wire logic        clk,       // Clock
	input  wire logic        mem_req,   // Request
	input  wire logic        mem_write, // Program access
	input  wire logic [31:0] mem_addr,  // Byte address
	input  wire logic [31:0] mem_wdata, // Program word
	input  wire logic [31:0] fail_addr, // Address that fails
	input  wire logic [3:0]  delay,     // Wait cycles
	output var  logic        mem_done,  // End pulse
	output var  logic        mem_error, // Program fail
	output var  logic [31:0] mem_rdata  // Read word
);
	// ========================================
	// Storage and timing
	logic [31:0] mem [logic [31:0]];
	logic [3:0]  cnt = 4'h0;
	initial begin
		mem_done = 1'b0;
		mem_error = 1'b0;
		mem_rdata = 32'h0;
	end
	// Read data toggles when not valid, so a stale word never looks right
	always @(posedge clk) begin
		mem_done <= 1'b0;
		mem_error <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_done) begin
			if (cnt == delay) begin
				cnt <= 4'h0;
				mem_done <= 1'b1;
				if (mem_write) begin
					mem[mem_addr] = mem_wdata;
					mem_error <= (mem_addr == fail_addr);
				end else begin
					mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
				end
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/test_fpcr_top.sv ***
// Self-checking bench of the command responder
`timescale 1ns/100ps
`default_nettype none
module test_fpcr_top;
	import fpcr_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [31:0] cmd_word = 32'h0;
	logic        rsp_ready = 1'b0;
	logic        stall = 1'b0;
	logic [3:0]  delay = 4'h0;
	logic [31:0] fail_addr = 32'hFFF0;
	logic        cmd_ready, rsp_valid, mem_req, mem_write, mem_done, mem_error;
	logic [31:0] rsp_word, mem_addr, mem_wdata, mem_rdata;
	int          error_cnt = 0;
	int          checks = 0;
	int          rows_sent = 0;
	int          sn;

	always #25 clk = ~clk;
	// Slow far side, once stall is set, is ready every other cycle
	always @(posedge clk) rsp_ready <= stall ? ~rsp_ready : 1'b1;

	fpcr_top dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
		.rsp_ready(rsp_ready), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_done(mem_done), .mem_error(mem_error),
		.mem_rdata(mem_rdata));
	fpcr_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .fail_addr(fail_addr), .delay(delay),
		.mem_done(mem_done), .mem_error(mem_error), .mem_rdata(mem_rdata));

	// ========================================
	// Shared tasks
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	// Valid stays up between words; callers lower it after the last one
	task automatic send(input logic [31:0] w);
		cmd_valid <= 1'b1;
		cmd_word <= w;
		do @(negedge clk); while (cmd_ready !== 1'b1);
		@(posedge clk);
	endtask
	task automatic get(input logic [31:0] exp, output int seen);
		do @(negedge clk); while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1));
		seen = rows_sent;
		cmp(rsp_word, exp);
		@(posedge clk);
	endtask
	task automatic hdr(input logic [31:0] h, input logic [31:0] a);
		send(h);
		send({16'h0, a[31:16]});
		send({16'h0, a[15:0]});
	endtask
	task automatic row(input logic [31:0] a);
		for (int i = 0; i < FPCR_ROW_WORDS; i++)
			send(pat(a + 32'(4 * i)));
	endtask
	task automatic rd(input logic [31:0] a, input logic [15:0] n, input logic [31:0] flip);
		hdr({FPCR_OP_READ, n}, a);
		cmd_valid <= 1'b0;
		get({FPCR_OP_READ, FPCR_RES_PASS}, sn);
		for (int i = 0; i < n; i++)
			get(pat(a + 32'(4 * i)) ^ {32{a + 32'(4 * i) == flip}}, sn);
	endtask

	// ========================================
	// Scenarios
	task automatic t_unknown;
		logic [15:0] codes [3] = '{16'h0004, 16'h00FF, 16'hFFFF};
		foreach (codes[i]) begin
			send({codes[i], 16'h1234});
			cmd_valid <= 1'b0;
			get({codes[i], unknown_command_code}, sn);
		end
	endtask
	task automatic t_row(input logic [31:0] a, input logic [15:0] code);
		hdr({FPCR_OP_ROW_WRITE, 16'hABCD}, a);
		row(a);
		cmd_valid <= 1'b0;
		get({FPCR_OP_ROW_WRITE, code}, sn);
	endtask
	task automatic t_word(input logic [31:0] a);
		hdr({FPCR_OP_WORD_WRITE, 16'h0}, a);
		send(~pat(a));
		cmd_valid <= 1'b0;
		get({FPCR_OP_WORD_WRITE, FPCR_RES_PASS}, sn);
		rd(a - 32'h4, 16'h3, a);
	endtask
	task automatic t_prog(input logic [31:0] a, input int n);
		rows_sent = 0;
		fork
			begin
				hdr({FPCR_OP_PROGRAM, 16'h0}, a);
				send(32'h0);
				send(FPCR_ROW_BYTES * 32'(n));
				for (int r = 0; r < n; r++) begin
					row(a + FPCR_ROW_BYTES * 32'(r));
					rows_sent++;
				end
				cmd_valid <= 1'b0;
			end
			for (int k = 0; k < n; k++) begin
				get({a[15:0] + 16'(k * 128), FPCR_RES_PASS}, sn);
				cmp(32'(sn >= ((k + 2 > n) ? n : k + 2)), 32'h1);
			end
		join
	endtask
	task automatic t_pfail(input logic [31:0] a);
		hdr({FPCR_OP_PROGRAM, 16'h0}, a);
		send(32'h0);
		send(FPCR_ROW_BYTES);
		row(a);
		cmd_valid <= 1'b0;
		get({a[15:0], FPCR_RES_FAIL}, sn);
		rd(a, 16'h20, 32'h1);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_unknown;
		t_row(32'h1000, FPCR_RES_PASS);
		rd(32'h1000, 16'h20, 32'h1);
		stall <= 1'b1;
		delay <= 4'h3;
		fail_addr <= 32'h3014;
		t_row(32'h3000, FPCR_RES_FAIL);
		t_pfail(32'h3000);
		t_word(32'h1010);
		for (int n = 1; n <= 3; n++)
			t_prog(32'h2000 + 32'(n) * 32'h400, n);
		rd(32'h2C00, 16'h60, 32'h1);
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end
endmodule
`default_nettype wire
